/* design/bisync_controller.sv */
// Command, status and character path of the bisync controller
// Summary of operation
// R01: Select code C3 makes us target
// R02: Stop resets state, status and sync code, clears parameters
// R03: Idle bit sets on completion, clears start
// R04: Match bit set on list hit
// R05: Receive errors set bit 5 until restart
// R06: Timer bit cleared by abort or stop
// R07: Overrun or forced-scan miss sets bit 2; a forced-scan miss in transmit leaves it clear
// R08: Bit1 live DSR, bit0 latched ring
// R09: Sync code byte is idle pattern
// R10: Two syncs validate data, carrier loss rehunts
// R11: Code bit selects ASCII or EBCDIC
// R12: LRC mode sends odd parity, checks it
// R13: CRC mode sends eight bits, no parity
// R14: Parameter bit 4 drives DTR
// R15: Start aborts and clears status bits
// R16: Transmit fetches, sends, terminates on end
// R17: Control character scans list, halts on match
// R18: Receive stores data, pointer marks match
// R19: Control test on bits 5,6 or 6,7
// R20: Software preloads every transmitted character
// R21: Termination address three beyond message end
// R22: Three second silence ends receive, bit 3
// R23: Protocol command resumes halted controller
`timescale 1ns/1ps
`default_nettype none
module bisync_controller
  import bisync_pkg::*;
#(
  parameter logic [TIMER_W-1:0] TIMER_LEN = TIMER_W'(TIMER_CYCLES),
  parameter logic [ACT_W-1:0] ACTIVITY_LEN = ACT_W'(ACTIVITY_CYCLES)
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // CPU I/O bus commands
  input wire logic selStrobe,
  input wire logic stopStrobe,
  input wire logic statusReadStrobe,
  input wire logic syncLoadStrobe,
  input wire logic paramSetStrobe,
  input wire logic ioStartStrobe,
  input wire logic protocolStrobe,
  input wire logic auxStrobe,
  input wire logic [7:0] cmdByte,
  output logic [7:0] statusData,
  output logic selected,
  output logic irq,
  // Active control list load
  input wire logic listWrEn,
  input wire logic [LIST_AW-1:0] listWrAddr,
  input wire logic [7:0] listWrData,
  input wire logic [LIST_AW-1:0] listLast,
  output logic [LIST_AW-1:0] ctlPtr,
  // Main channel buffer
  output logic bufRdReq,
  input wire logic bufRdValid,
  input wire logic bufRdTerm,
  input wire logic [7:0] bufRdData,
  output logic bufWrValid,
  output logic [7:0] bufWrData,
  input wire logic bufWrTerm,
  // Line characters
  output logic lineTxValid,
  output logic [7:0] lineTxData,
  input wire logic lineTxReady,
  input wire logic lineRxValid,
  input wire logic [7:0] lineRxData,
  // Modem pins
  input wire logic dsrPin,
  input wire logic ringPin,
  input wire logic carrierPin,
  output logic dtr
);
  // ============
  // Helpers
  function automatic logic isControl(input logic [7:0] c, input logic ascii);
    // R19: control character test
    isControl = ascii ? (c[5] == 1'b0 && c[6] == 1'b0) : (c[6] == 1'b0 && c[7] == 1'b0);
  endfunction : isControl

  function automatic logic [7:0] lineByte(input logic [7:0] c, input logic lrc);
    // R12: seven bits plus odd parity
    // R13: eight bits unchanged
    lineByte = lrc ? {~^c[6:0], c[6:0]} : c;
  endfunction : lineByte

  // ============
  // Modem pin synchronisers
  logic [2:0] pinS1_q, pinS2_q, pinS3_q, pinF_q;
  logic [2:0] pinF_d;

  always_comb begin
    pinF_d = pinF_q;
    for (int i = 0; i < 3; i++) begin
      if (pinS2_q[i] == pinS3_q[i]) begin
        pinF_d[i] = pinS2_q[i];
      end
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pinS1_q <= 3'h0;
      pinS2_q <= 3'h0;
      pinS3_q <= 3'h0;
      pinF_q <= 3'h0;
    end else begin
      pinS1_q <= {carrierPin, ringPin, dsrPin};
      pinS2_q <= pinS1_q;
      pinS3_q <= pinS2_q;
      pinF_q <= pinF_d;
    end
  end

  logic dsrF, ringF, carrierF;
  assign dsrF = pinF_q[0];
  assign ringF = pinF_q[1];
  assign carrierF = pinF_q[2];

  // ============
  // Control list memory
  logic [LIST_AW-1:0] scanIdx_q, scanIdx_d;
  logic [7:0] listRdData;

  ctl_list_mem u_list (
    .clk(clk),
    .wrEn(listWrEn),
    .wrAddr(listWrAddr),
    .wrData(listWrData),
    .rdAddr(scanIdx_q),
    .rdData(listRdData)
  );

  // ============
  // Controller state
  state_type state_q, state_d;
  logic sel_q, sel_d, irq_q, irq_d, txMode_q, txMode_d;
  logic force_q, force_d, forced_q, forced_d, term_q, term_d;
  logic ringMode_q, ringMode_d, timerRun_q, timerRun_d;
  logic [7:0] status_q, status_d, statusData_q, statusData_d;
  logic [7:0] param_q, param_d, syncCode_q, syncCode_d, hold_q, hold_d;
  logic [1:0] syncCnt_q, syncCnt_d;
  logic [TIMER_W-1:0] timerCnt_q, timerCnt_d;
  logic [ACT_W-1:0] actCnt_q, actCnt_d;
  logic [LIST_AW-1:0] ctlPtr_q, ctlPtr_d;
  logic bufRdReq_q, bufRdReq_d, bufWr_q, bufWr_d, txValid_q, txValid_d;
  logic [7:0] bufWrData_q, bufWrData_d, txData_q, txData_d;
  logic cmdOk, rxBusy;

  // R01: commands only while selected
  assign cmdOk = sel_q;
  assign rxBusy = !txMode_q && state_q != S_IDLE;

  always_comb begin
    state_d = state_q;
    sel_d = sel_q;
    irq_d = irq_q;
    txMode_d = txMode_q;
    force_d = force_q;
    forced_d = forced_q;
    term_d = term_q;
    ringMode_d = ringMode_q;
    timerRun_d = timerRun_q;
    status_d = status_q;
    statusData_d = statusData_q;
    param_d = param_q;
    syncCode_d = syncCode_q;
    hold_d = hold_q;
    syncCnt_d = syncCnt_q;
    timerCnt_d = timerCnt_q;
    actCnt_d = actCnt_q;
    ctlPtr_d = ctlPtr_q;
    scanIdx_d = scanIdx_q;
    bufRdReq_d = 1'b0;
    bufWr_d = 1'b0;
    bufWrData_d = bufWrData_q;
    txValid_d = txValid_q && !lineTxReady;
    txData_d = txData_q;

    // R01: select or deselect
    if (selStrobe) begin
      sel_d = (cmdByte == SELECT_CODE);
    end
    // R08: live dataset ready
    status_d[ST_DSR] = dsrF;

    // Character engine
    if (state_q != S_IDLE) begin
      actCnt_d = actCnt_q + ACT_W'(1);
    end
    case (state_q)
      S_IDLE: begin
      end
      S_TX_FETCH: begin
        bufRdReq_d = 1'b1;
        state_d = S_TX_WAIT;
      end
      S_TX_WAIT: begin
        if (bufRdValid) begin
          // R16: end of buffer completes transmit
          if (bufRdTerm) begin
            state_d = S_IDLE;
            status_d[ST_IDLE] = 1'b1;
            irq_d = 1'b1;
          end else begin
            hold_d = bufRdData;
            // R17: control characters go to the scan
            if (isControl(bufRdData, param_q[PAR_ASCII]) || force_q) begin
              forced_d = force_q;
              force_d = 1'b0;
              scanIdx_d = '0;
              state_d = S_SCAN_RD;
            end else begin
              state_d = S_TX_SEND;
            end
          end
        end
      end
      S_TX_SEND: begin
        // R16: non-control characters go to the line
        if (!txValid_q) begin
          txValid_d = 1'b1;
          txData_d = lineByte(hold_q, param_q[PAR_LRC]);
          actCnt_d = '0;
          state_d = term_q ? S_IDLE : S_TX_FETCH;
          status_d[ST_IDLE] = term_q;
          irq_d = irq_q || term_q;
          term_d = 1'b0;
        end
      end
      S_RX_HUNT: begin
        // R09: sync code is the expected idle pattern
        // R10: two consecutive syncs before data
        if (lineRxValid) begin
          if (lineRxData == syncCode_q) begin
            actCnt_d = '0;
            syncCnt_d = syncCnt_q + 2'd1;
            if (syncCnt_q == 2'(SYNC_NEEDED - 1)) begin
              state_d = S_RX_DATA;
            end
          end else begin
            syncCnt_d = 2'd0;
          end
        end
      end
      S_RX_DATA: begin
        if (!carrierF) begin
          // R10: carrier loss forces a new hunt
          syncCnt_d = 2'd0;
          state_d = S_RX_HUNT;
        end else if (lineRxValid) begin
          if (lineRxData == syncCode_q && !force_q) begin
            actCnt_d = '0;
          end else begin
            hold_d = lineRxData;
            // R12: odd parity check in LRC mode
            if (param_q[PAR_LRC] && !(^lineRxData)) begin
              status_d[ST_RXERR] = 1'b1;
            end
            // R18: control characters scanned, data stored
            if (isControl(lineRxData, param_q[PAR_ASCII]) || force_q) begin
              forced_d = force_q;
              force_d = 1'b0;
              scanIdx_d = '0;
              state_d = S_SCAN_RD;
            end else begin
              bufWr_d = 1'b1;
              bufWrData_d = lineRxData;
              if (bufWrTerm) begin
                state_d = S_IDLE;
                status_d[ST_IDLE] = 1'b1;
                irq_d = 1'b1;
              end
            end
          end
        end
      end
      S_SCAN_RD: begin
        state_d = S_SCAN_CMP;
      end
      S_SCAN_CMP: begin
        if (listRdData == hold_q) begin
          // R17: match halts with bit 6 and interrupt
          // R04: match bit set
          // R18: pointer left on matching entry
          status_d[ST_MATCH] = 1'b1;
          irq_d = 1'b1;
          ctlPtr_d = scanIdx_q;
          state_d = S_HALT;
        end else if (scanIdx_q == listLast) begin
          // R07: forced scan found no entry
          if (forced_q && !txMode_q) begin
            status_d[ST_OVR] = 1'b1;
          end
          // R17: no match, handled as data
          if (txMode_q) begin
            state_d = S_TX_SEND;
          end else begin
            bufWr_d = 1'b1;
            bufWrData_d = hold_q;
            state_d = bufWrTerm ? S_IDLE : S_RX_DATA;
            status_d[ST_IDLE] = bufWrTerm;
            irq_d = irq_q || bufWrTerm;
          end
        end else begin
          scanIdx_d = scanIdx_q + LIST_AW'(1);
          state_d = S_SCAN_RD;
        end
      end
      S_HALT: begin
      end
      default: begin
        state_d = S_IDLE;
      end
    endcase

    // R05: receive overrun sets bits 5 and 2
    // R07: data overrun in receive
    if (rxBusy && lineRxValid && state_q != S_RX_DATA && state_q != S_RX_HUNT) begin
      status_d[ST_RXERR] = 1'b1;
      status_d[ST_OVR] = 1'b1;
    end
    // R22: three seconds of silence end the operation
    if (state_q != S_IDLE && state_q != S_HALT && actCnt_q >= ACTIVITY_LEN - ACT_W'(1)) begin
      status_d[ST_ACT] = 1'b1;
      status_d[ST_IDLE] = 1'b1;
      irq_d = 1'b1;
      state_d = S_IDLE;
    end

    // Command bus
    if (cmdOk && statusReadStrobe) begin
      statusData_d = status_q;
    end
    if (cmdOk && syncLoadStrobe) begin
      syncCode_d = cmdByte;
    end
    // R11: parameter byte holds code select
    // R14: DTR follows parameter bit
    if (cmdOk && paramSetStrobe) begin
      param_d = cmdByte;
    end
    if (cmdOk && protocolStrobe) begin
      // R04: protocol clears match bit, a new match wins
      status_d[ST_MATCH] = status_d[ST_MATCH] && !status_q[ST_MATCH];
      irq_d = irq_d && !irq_q;
      force_d = cmdByte[PR_FORCE];
      // R23: protocol command resumes a halt
      if (state_q == S_HALT) begin
        if (txMode_q) begin
          term_d = cmdByte[PR_TERM];
          state_d = cmdByte[PR_ACCEPT] ? S_TX_SEND : (cmdByte[PR_TERM] ? S_IDLE : S_TX_FETCH);
        end else begin
          bufWr_d = cmdByte[PR_ACCEPT];
          bufWrData_d = hold_q;
          state_d = cmdByte[PR_TERM] ? S_IDLE : S_RX_DATA;
        end
        if (!txMode_q || !cmdByte[PR_ACCEPT]) begin
          status_d[ST_IDLE] = cmdByte[PR_TERM];
          irq_d = cmdByte[PR_TERM];
        end
      end else if (state_q != S_IDLE) begin
        term_d = cmdByte[PR_TERM];
      end
    end
    if (cmdOk && auxStrobe) begin
      if (cmdByte[AX_IRQCLR]) begin
        irq_d = irq_d && !irq_q;
      end
      if (cmdByte[AX_ABORT]) begin
        timerRun_d = 1'b0;
        status_d[ST_TIMER] = 1'b0;
      end
      if (cmdByte[AX_START]) begin
        timerRun_d = 1'b1;
        timerCnt_d = '0;
      end
      if (cmdByte[AX_RCLR]) begin
        ringMode_d = 1'b0;
        status_d[ST_RING] = 1'b0;
      end else if (cmdByte[AX_RSET]) begin
        ringMode_d = 1'b1;
      end
      if (cmdByte[AX_IRQSET]) begin
        irq_d = 1'b1;
      end
    end
    // R15: start aborts and clears status bits except timer bit 4 and DSR bit 1
    // R03: transmit or receive start clears idle bit, any other start code sets it
    if (cmdOk && ioStartStrobe) begin
      status_d = status_d & 8'h00_12;
      irq_d = 1'b0;
      ringMode_d = 1'b0;
      force_d = 1'b0;
      term_d = 1'b0;
      syncCnt_d = 2'd0;
      actCnt_d = '0;
      txValid_d = 1'b0;
      txMode_d = (cmdByte == IO_TRANSMIT);
      if (cmdByte == IO_TRANSMIT) begin
        state_d = S_TX_FETCH;
      end else if (cmdByte == IO_RECEIVE) begin
        state_d = S_RX_HUNT;
      end else begin
        state_d = S_IDLE;
        status_d[ST_IDLE] = 1'b1;
      end
    end

    // R06: one second timer expiry
    if (timerRun_q) begin
      timerCnt_d = timerCnt_q + TIMER_W'(1);
      if (timerCnt_q >= TIMER_LEN - TIMER_W'(1)) begin
        timerRun_d = 1'b0;
        status_d[ST_TIMER] = 1'b1;
        irq_d = 1'b1;
      end
    end
    // R08: ring latched only in ring mode
    if (ringMode_d && ringF && !status_q[ST_RING]) begin
      status_d[ST_RING] = 1'b1;
      irq_d = 1'b1;
    end

    // R02: stop resets controller and parameters
    // R03: stop sets idle bit
    if (cmdOk && stopStrobe) begin
      state_d = S_IDLE;
      status_d = STATUS_RESET;
      status_d[ST_DSR] = dsrF;
      param_d = PARAM_RESET;
      syncCode_d = SYNC_RESET;
      timerRun_d = 1'b0;
      ringMode_d = 1'b0;
      force_d = 1'b0;
      term_d = 1'b0;
      txValid_d = 1'b0;
      bufRdReq_d = 1'b0;
      bufWr_d = 1'b0;
      irq_d = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state_q <= S_IDLE;
      sel_q <= 1'b0;
      irq_q <= 1'b0;
      txMode_q <= 1'b0;
      force_q <= 1'b0;
      forced_q <= 1'b0;
      term_q <= 1'b0;
      ringMode_q <= 1'b0;
      timerRun_q <= 1'b0;
      status_q <= STATUS_RESET;
      statusData_q <= 8'h00_00;
      param_q <= PARAM_RESET;
      syncCode_q <= SYNC_RESET;
      hold_q <= 8'h00_00;
      syncCnt_q <= 2'd0;
      timerCnt_q <= '0;
      actCnt_q <= '0;
      ctlPtr_q <= '0;
      scanIdx_q <= '0;
      bufRdReq_q <= 1'b0;
      bufWr_q <= 1'b0;
      bufWrData_q <= 8'h00_00;
      txValid_q <= 1'b0;
      txData_q <= 8'h00_00;
    end else begin
      state_q <= state_d;
      sel_q <= sel_d;
      irq_q <= irq_d;
      txMode_q <= txMode_d;
      force_q <= force_d;
      forced_q <= forced_d;
      term_q <= term_d;
      ringMode_q <= ringMode_d;
      timerRun_q <= timerRun_d;
      status_q <= status_d;
      statusData_q <= statusData_d;
      param_q <= param_d;
      syncCode_q <= syncCode_d;
      hold_q <= hold_d;
      syncCnt_q <= syncCnt_d;
      timerCnt_q <= timerCnt_d;
      actCnt_q <= actCnt_d;
      ctlPtr_q <= ctlPtr_d;
      scanIdx_q <= scanIdx_d;
      bufRdReq_q <= bufRdReq_d;
      bufWr_q <= bufWr_d;
      bufWrData_q <= bufWrData_d;
      txValid_q <= txValid_d;
      txData_q <= txData_d;
    end
  end

  // ============
  // Outputs
  assign statusData = statusData_q;
  assign selected = sel_q;
  assign irq = irq_q;
  assign ctlPtr = ctlPtr_q;
  assign bufRdReq = bufRdReq_q;
  assign bufWrValid = bufWr_q;
  assign bufWrData = bufWrData_q;
  assign lineTxValid = txValid_q;
  assign lineTxData = txData_q;
  assign dtr = param_q[PAR_DTR];
endmodule : bisync_controller
`default_nettype wire

/* design/bisync_pkg.sv */
// Shared constants and types of the bisync command and status logic
package bisync_pkg;
  // ============
  // Command codes
  localparam logic [7:0] SELECT_CODE = 8'h00_C3;
  localparam logic [7:0] IO_TRANSMIT = 8'h00_80;
  localparam logic [7:0] IO_RECEIVE = 8'h00_40;
  // ============
  // Status bit positions
  localparam int ST_IDLE = 7;
  localparam int ST_MATCH = 6;
  localparam int ST_RXERR = 5;
  localparam int ST_TIMER = 4;
  localparam int ST_ACT = 3;
  localparam int ST_OVR = 2;
  localparam int ST_DSR = 1;
  localparam int ST_RING = 0;
  localparam logic [7:0] STATUS_RESET = 8'h00_80;
  // ============
  // Line parameters
  localparam int PAR_ASCII = 7;
  localparam int PAR_LRC = 6;
  localparam int PAR_DTR = 4;
  localparam logic [7:0] PARAM_RESET = 8'h00_00;
  localparam logic [7:0] SYNC_RESET = 8'h00_00;
  // ============
  // Protocol and auxiliary bits
  localparam int PR_ACCEPT = 7;
  localparam int PR_TERM = 4;
  localparam int PR_FORCE = 3;
  localparam int AX_START = 7;
  localparam int AX_ABORT = 6;
  localparam int AX_RSET = 5;
  localparam int AX_RCLR = 4;
  localparam int AX_IRQCLR = 1;
  localparam int AX_IRQSET = 0;
  // ============
  // Timing
  localparam int CLK_MHZ = 100;
  localparam int TIMER_MS = 1000;
  localparam int ACTIVITY_MS = 3000;
  localparam int TIMER_CYCLES = TIMER_MS * 1000 * CLK_MHZ;
  localparam int ACTIVITY_CYCLES = ACTIVITY_MS * 1000 * CLK_MHZ;
  localparam int TIMER_W = 27;
  localparam int ACT_W = 29;
  localparam int SYNC_NEEDED = 2;
  // ============
  // Active control list
  localparam int LIST_AW = 4;
  // ============
  // Controller states
  typedef enum logic [3:0] {
    S_IDLE = 4'b0000,
    S_TX_FETCH = 4'b0001,
    S_TX_WAIT = 4'b0010,
    S_TX_SEND = 4'b0011,
    S_RX_HUNT = 4'b0100,
    S_RX_DATA = 4'b0101,
    S_SCAN_RD = 4'b0110,
    S_SCAN_CMP = 4'b0111,
    S_HALT = 4'b1000
  } state_type;
endpackage : bisync_pkg

/* design/ctl_list_mem.sv */
// Active control character list memory with registered read data
`timescale 1ns/1ps
`default_nettype none
module ctl_list_mem
  import bisync_pkg::*;
(
  // Clock
  input wire logic clk,
  // Write port
  input wire logic wrEn,
  input wire logic [LIST_AW-1:0] wrAddr,
  input wire logic [7:0] wrData,
  // Read port
  input wire logic [LIST_AW-1:0] rdAddr,
  output logic [7:0] rdData
);
  logic [7:0] mem [0:(1<<LIST_AW)-1];

  always_ff @(posedge clk) begin
    if (wrEn) begin
      mem[wrAddr] <= wrData;
    end
    rdData <= mem[rdAddr];
  end
endmodule : ctl_list_mem
`default_nettype wire

/* verif/bisync_controller_properties.sv */
// Port-level assertions for the bisync command and status logic
`timescale 1ns/1ps
`default_nettype none
module bisync_controller_properties
  import bisync_pkg::*;
#(
  parameter logic [TIMER_W-1:0] TIMER_LEN = TIMER_W'(TIMER_CYCLES),
  parameter logic [ACT_W-1:0] ACTIVITY_LEN = ACT_W'(ACTIVITY_CYCLES)
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Commands
  input wire logic selStrobe,
  input wire logic stopStrobe,
  input wire logic statusReadStrobe,
  input wire logic paramSetStrobe,
  input wire logic ioStartStrobe,
  input wire logic auxStrobe,
  input wire logic [7:0] cmdByte,
  input wire logic [7:0] statusData,
  input wire logic selected,
  input wire logic irq,
  // Channel and modem
  input wire logic bufRdReq,
  input wire logic lineTxValid,
  input wire logic [7:0] lineTxData,
  input wire logic lineTxReady,
  input wire logic dsrPin,
  input wire logic dtr
);
  localparam int TMAX = 1000;
  logic lrcMode_q;
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  // ============
  // Block check mode as last set
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) lrcMode_q <= 1'b0;
    else if (selected && stopStrobe) lrcMode_q <= 1'b0;
    else if (selected && paramSetStrobe) lrcMode_q <= cmdByte[PAR_LRC];
  end
  // ============
  // Properties
  sel_code_a: assert property (selStrobe && cmdByte == SELECT_CODE |=> selected)
    else $error("select failed");
  desel_code_a: assert property (selStrobe && cmdByte != SELECT_CODE |=> !selected)
    else $error("deselect failed");
  unsel_ignore_a: assert property (!selected |=> $stable(dtr))
    else $error("command taken unselected");
  dtr_on_a: assert property (selected && paramSetStrobe && !stopStrobe
    && cmdByte[PAR_DTR] |-> ##2 dtr)
    else $error("no terminal ready");
  stop_abort_a: assert property (selected && stopStrobe
    |=> irq && !dtr && !lineTxValid && !bufRdReq)
    else $error("stop left activity");
  start_tx_a: assert property (selected && ioStartStrobe && !stopStrobe
    && cmdByte == IO_TRANSMIT |=> !irq ##1 bufRdReq)
    else $error("no fetch after start");
  fetch_pulse_a: assert property (bufRdReq |=> !bufRdReq)
    else $error("fetch request too long");
  tx_hold_a: assert property (lineTxValid && !lineTxReady && !stopStrobe
    && !ioStartStrobe |=> lineTxValid && $stable(lineTxData))
    else $error("line character dropped");
  lrc_parity_a: assert property (lineTxValid && lrcMode_q |-> ^lineTxData)
    else $error("even parity sent");
  dsr_status_a: assert property (dsrPin[*8] ##0
    (selected && statusReadStrobe && !stopStrobe) |=> statusData[ST_DSR])
    else $error("ready bit missing");
  timer_expire_a: assert property (selected && auxStrobe && cmdByte[AX_START]
    && !stopStrobe && (TIMER_LEN < 900) |-> ##[1:TMAX] irq)
    else $error("timer expiry missed");
endmodule : bisync_controller_properties
bind bisync_controller bisync_controller_properties #(.TIMER_LEN(TIMER_LEN),
  .ACTIVITY_LEN(ACTIVITY_LEN)) props_i (.clk(clk), .rstn(rstn), .selStrobe(selStrobe),
  .stopStrobe(stopStrobe), .statusReadStrobe(statusReadStrobe),
  .paramSetStrobe(paramSetStrobe), .ioStartStrobe(ioStartStrobe), .auxStrobe(auxStrobe),
  .cmdByte(cmdByte), .statusData(statusData), .selected(selected), .irq(irq),
  .bufRdReq(bufRdReq), .lineTxValid(lineTxValid), .lineTxData(lineTxData),
  .lineTxReady(lineTxReady), .dsrPin(dsrPin), .dtr(dtr));
`default_nettype wire

/* verif/modem_model.sv */
// Synchronous modem stand-in for the line side
`timescale 1ns/1ps
`default_nettype none
module modem_model (
  // Clock
  input wire logic clk,
  // Line characters
  input wire logic lineTxValid,
  input wire logic [7:0] lineTxData,
  output logic lineTxReady,
  output logic lineRxValid,
  output logic [7:0] lineRxData,
  // Modem pins
  output logic dsrPin,
  output logic ringPin,
  output logic carrierPin
);
  logic [7:0] txSeen[$];
  logic [1:0] slowCnt;
  initial begin
    slowCnt = 2'h0;
    lineTxReady = 1'b0;
    lineRxValid = 1'b0;
    lineRxData = 8'h00_A5;
    dsrPin = 1'b1;
    ringPin = 1'b0;
    carrierPin = 1'b1;
  end
  // Slow line: takes one character every fourth cycle
  always @(posedge clk) begin
    slowCnt <= slowCnt + 2'h1;
    lineTxReady <= (slowCnt == 2'h2);
    if (lineTxValid && lineTxReady) txSeen.push_back(lineTxData);
  end
  // Released data shows the inverse
  task automatic rxByte(input logic [7:0] b);
    @(posedge clk);
    lineRxValid <= 1'b1;
    lineRxData <= b;
    @(posedge clk);
    lineRxValid <= 1'b0;
    lineRxData <= ~b;
    repeat (12) @(posedge clk);
  endtask : rxByte
  task automatic ring();
    @(posedge clk);
    ringPin <= 1'b1;
    repeat (8) @(posedge clk);
    ringPin <= 1'b0;
  endtask : ring
endmodule : modem_model
`default_nettype wire

/* verif/tb_bisync_controller.sv */
// Command-level testbench for the bisync controller
`timescale 1ns/1ps
`default_nettype none
module tb_bisync_controller;
  import bisync_pkg::*;
  logic clk, rstn, selected, irq, listWrEn, bufRdReq, bufRdValid, bufRdTerm, bufWrValid;
  logic lineTxValid, lineTxReady, lineRxValid, dsrPin, ringPin, carrierPin, dtr;
  logic [7:0] strb, cmdByte, statusData, listWrData, bufRdData, bufWrData;
  logic [7:0] lineTxData, lineRxData;
  logic [3:0] listWrAddr, listLast, ctlPtr;
  logic [7:0] txBuf[$];
  logic [7:0] rxSeen[$];
  int rdIdx, fails, n_checks;
  bisync_controller #(.TIMER_LEN(27'h00_C8), .ACTIVITY_LEN(29'h01_F4)) bisync_controller_i (
    .clk(clk), .rstn(rstn), .selStrobe(strb[0]), .stopStrobe(strb[1]),
    .statusReadStrobe(strb[2]), .syncLoadStrobe(strb[3]), .paramSetStrobe(strb[4]),
    .ioStartStrobe(strb[5]), .protocolStrobe(strb[6]), .auxStrobe(strb[7]),
    .cmdByte(cmdByte), .statusData(statusData), .selected(selected), .irq(irq),
    .listWrEn(listWrEn), .listWrAddr(listWrAddr), .listWrData(listWrData),
    .listLast(listLast), .ctlPtr(ctlPtr), .bufRdReq(bufRdReq), .bufRdValid(bufRdValid),
    .bufRdTerm(bufRdTerm), .bufRdData(bufRdData), .bufWrValid(bufWrValid),
    .bufWrData(bufWrData), .bufWrTerm(1'b0), .lineTxValid(lineTxValid),
    .lineTxData(lineTxData), .lineTxReady(lineTxReady), .lineRxValid(lineRxValid),
    .lineRxData(lineRxData), .dsrPin(dsrPin), .ringPin(ringPin), .carrierPin(carrierPin),
    .dtr(dtr));
  modem_model modem_model_i (.clk(clk), .lineTxValid(lineTxValid), .lineTxData(lineTxData),
    .lineTxReady(lineTxReady), .lineRxValid(lineRxValid), .lineRxData(lineRxData),
    .dsrPin(dsrPin), .ringPin(ringPin), .carrierPin(carrierPin));
  // ============
  // Clock, buffer memory and watchdog
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) begin
    bufRdValid <= bufRdReq;
    bufRdTerm <= bufRdReq && rdIdx >= txBuf.size();
    if (bufRdReq && rdIdx < txBuf.size()) begin
      bufRdData <= txBuf[rdIdx];
      rdIdx <= rdIdx + 1;
    end
    if (bufWrValid) rxSeen.push_back(bufWrData);
  end
  initial begin
    #200000;
    fails++;
    end_of_test();
  end
  // ============
  // Tasks
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic cmd(input int k, input logic [7:0] b);
    @(posedge clk);
    strb <= 8'h00_01 << k;
    cmdByte <= b;
    @(posedge clk);
    strb <= 8'h00_00;
  endtask : cmd
  task automatic rdSt(input logic [7:0] e, input logic [7:0] m);
    cmd(2, 8'h00_00);
    #1 chk(statusData & m, e);
  endtask : rdSt
  task automatic waitIrq();
    #1;
    for (int i = 0; irq !== 1'b1 && i < 3000; i++) @(posedge clk) #1;
    chk(8'(irq), 8'h00_01);
  endtask : waitIrq
  task automatic cmpQ(input logic [7:0] got[$], input logic [7:0] exp[$]);
    chk(8'(got.size()), 8'(exp.size()));
    foreach (exp[i]) chk(got[i], exp[i]);
  endtask : cmpQ
  task automatic txRun(input logic [7:0] prm, input logic [7:0] d[$]);
    cmd(4, prm);
    cmd(3, 8'h00_32);
    txBuf = d;
    rdIdx = 0;
    modem_model_i.txSeen.delete();
    cmd(5, IO_TRANSMIT);
  endtask : txRun
  task automatic end_of_test();
    $display("checks %0d errors %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : end_of_test
  // ============
  // Sequence
  initial begin
    logic [7:0] prms[2];
    logic [7:0] q[$];
    prms = '{8'h00_80, 8'h00_C0};
    {strb, cmdByte, listWrData, listWrAddr, listLast, listWrEn} = '0;
    {bufRdValid, bufRdTerm, bufRdData, rdIdx, fails, n_checks} = '0;
    rstn = 1'b0;
    repeat (4) @(posedge clk);
    rstn <= 1'b1;
    repeat (6) @(posedge clk);
    cmd(4, 8'h00_10);
    repeat (2) @(posedge clk);
    chk(8'(dtr), 8'h00_00);
    cmd(0, SELECT_CODE);
    rdSt(8'h00_82, 8'h00_FF);
    cmd(4, 8'h00_10);
    repeat (2) @(posedge clk);
    chk(8'(dtr), 8'h00_01);
    cmd(1, 8'h00_00);
    repeat (2) @(posedge clk);
    chk({dtr, irq}, 8'h00_01);
    rdSt(8'h00_82, 8'h00_FF);
    foreach (prms[i]) begin
      @(posedge clk);
      listWrEn <= 1'b1;
      listWrAddr <= 4'(i);
      listWrData <= i ? 8'h00_10 : 8'h00_03;
    end
    @(posedge clk);
    listWrEn <= 1'b0;
    listLast <= 4'h1;
    foreach (prms[j]) begin
      q = '{8'h00_41, 8'h00_83, 8'h00_C2};
      txRun(prms[j], q);
      waitIrq();
      rdSt(8'h00_82, 8'h00_FF);
      foreach (q[i]) if (prms[j][PAR_LRC]) q[i] = {~^q[i][6:0], q[i][6:0]};
      cmpQ(modem_model_i.txSeen, q);
    end
    q = '{8'h00_41, 8'h00_03, 8'h00_42};
    txRun(8'h00_80, q);
    waitIrq();
    rdSt(8'h00_42, 8'h00_FF);
    chk(8'(ctlPtr), 8'h00_00);
    cmd(6, 8'h00_80);
    #1 chk(8'(irq), 8'h00_00);
    waitIrq();
    cmpQ(modem_model_i.txSeen, q);
    cmd(4, 8'h00_00);
    cmd(3, 8'h00_32);
    cmd(5, IO_RECEIVE);
    q = '{8'h00_55, 8'h00_32, 8'h00_32, 8'h00_C1, 8'h00_10};
    foreach (q[i]) modem_model_i.rxByte(q[i]);
    waitIrq();
    rdSt(8'h00_40, 8'h00_FD);
    chk(8'(ctlPtr), 8'h00_01);
    modem_model_i.rxByte(8'h00_C3);
    rdSt(8'h00_64, 8'h00_FD);
    cmd(6, 8'h00_80);
    modem_model_i.rxByte(8'h00_C2);
    cmpQ(rxSeen, '{8'h00_C1, 8'h00_10, 8'h00_C2});
    cmd(5, IO_RECEIVE);
    rdSt(8'h00_00, 8'h00_FD);
    waitIrq();
    rdSt(8'h00_08, 8'h00_08);
    cmd(5, 8'h00_00);
    rdSt(8'h00_00, 8'h00_08);
    cmd(7, 8'h00_22);
    modem_model_i.ring();
    waitIrq();
    rdSt(8'h00_01, 8'h00_01);
    cmd(7, 8'h00_10);
    rdSt(8'h00_00, 8'h00_01);
    cmd(7, 8'h00_82);
    waitIrq();
    rdSt(8'h00_10, 8'h00_10);
    cmd(7, 8'h00_40);
    rdSt(8'h00_00, 8'h00_10);
    cmd(0, 8'h00_00);
    #1 chk(8'(selected), 8'h00_00);
    end_of_test();
  end
endmodule : tb_bisync_controller
`default_nettype wire
